/* inc/io_function_mux_defines.vh */
// offsets, field layouts, pin tables and reset values of the io function mux
`ifndef IO_FUNCTION_MUX_DEFINES_VH
`define IO_FUNCTION_MUX_DEFINES_VH

`define NUM_PINS 22
`define LP_PINS 8
`define ADDR_W 8

// register byte offsets
`define SEL_LO_ADDR 8'h00
`define SEL_HI_ADDR 8'h04
`define LP_SEL_ADDR 8'h08
`define CTRL_ADDR 8'h0C
`define STATUS_ADDR 8'h10
`define PAD_LEVEL_ADDR 8'h14

// function select codes
`define SEL_W 2
`define FUNC_0 2'h0
`define FUNC_1 2'h1
`define FUNC_2 2'h2
`define FUNC_BAD 2'h3

// control fields
`define CTRL_USB_OWN_BIT 0
`define CTRL_DBG_USB_BIT 1

// reset values
`define SEL_RST 44'h000_0000_0000
`define LP_SEL_RST 8'h00
`define USB_OWN_RST 1'b1
`define DBG_USB_RST 1'b0

// per-pin tables, bit n is pad index n
// function 0 is a general io on these pads
`define F0_GPIO_MASK 22'h00_3F0F
// function 0 input present (forced-high when unselected)
`define F0_IN_MASK 22'h3F_8070
// function 0 inputs forced low when unselected
`define F0_IN_LOW_MASK 22'h00_0000
// function 0 can drive the pad
`define F0_OUT_MASK 22'h3D_4080
// function 0 output may release to high impedance
`define F0_TRI_MASK 22'h3D_0080
// pads that carry function 2 at all
`define F2_MASK 22'h0F_C0F4
`define F2_IN_MASK 22'h00_40F4
`define F2_IN_LOW_MASK 22'h00_0000
// four dedicated debug pads
`define DBG_MASK 22'h00_00F0
// pads shared with the usb data lines
`define USB_MASK 22'h00_0C00

`endif

/* rtl/lowpower_mux.v */
// low-power pin multiplexer, live during deep sleep
`timescale 1ns/10ps
`default_nettype none
module lowpower_mux (
  input wire [7:0] lp_sel, // per lp pin: 0 lp gpio, 1 lp peripheral
  input wire [7:0] lp_gpio_out, // lp gpio output levels
  input wire [7:0] lp_gpio_oe, // lp gpio output enables
  input wire [7:0] periph_out, // lp peripheral outputs, pin order
  input wire [7:0] periph_oe, // lp peripheral output enables
  input wire [7:0] pad_in, // lp pad levels
  output reg [7:0] pad_out, // lp pad drive levels
  output reg [7:0] pad_oe, // lp pad enables
  output reg [7:0] lp_gpio_in, // lp gpio input levels
  output reg [7:0] periph_in // lp peripheral inputs, pin order
);

  integer i;

  always @* begin
    pad_out = 8'h00;
    pad_oe = 8'h00;
    lp_gpio_in = 8'h00;
    periph_in = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      // lp gpio level always visible to the lp processor
      lp_gpio_in[i] = pad_in[i]; // [R8]
      if (lp_sel[i]) begin
        pad_out[i] = periph_out[i]; // [R9]
        pad_oe[i] = periph_oe[i];
        periph_in[i] = pad_in[i];
      end else begin
        pad_out[i] = lp_gpio_out[i]; // [R8]
        pad_oe[i] = lp_gpio_oe[i];
        // idle uart and i2c lines sit high
        periph_in[i] = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/io_function_mux.v */
// io function multiplexer with register port and low-power takeover
//
// What this block does
// R1 - each general pad has exactly one of functions zero to two selected
// R2 - unselected forced-high peripheral inputs read constant one
// R3 - unselected forced-low peripheral inputs read constant zero
// R4 - each function is input, output or high impedance on the pad
// R5 - after reset every pad carries its default function without software
// R6 - in deep sleep the main mux routes nothing to or from pads
// R7 - in deep sleep the low-power mux serves the low-power pads
// R8 - low-power function zero is a low-power gpio
// R9 - low-power function one is uart handshakes, uart data, then i2c
// R10 - low-power selection is indexed by low-power gpio number
// R11 - every pad has a gpio function, eight also a low-power one
// R12 - software frees the usb pads before using them as gpio
// R13 - debug port may move to usb, releasing the four debug pads
// R14 - pad drive and peripheral input switch together in one cycle
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "io_function_mux_defines.vh"
module io_function_mux (
  input wire ref_clk, // clock, 40 MHz
  input wire reset, // synchronous, active high
  input wire [7:0] addr, // register byte address
  input wire [31:0] wdata, // register write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [31:0] rdata, // read data, cycle after rd
  input wire deep_sleep, // chip in deep sleep
  input wire [21:0] pad_in, // pad levels
  output reg [21:0] pad_out, // pad drive levels
  output reg [21:0] pad_oe, // pad output enables
  input wire [21:0] gpio_out, // gpio matrix outputs
  input wire [21:0] gpio_oe, // gpio matrix output enables
  output reg [21:0] gpio_in, // gpio matrix inputs
  input wire [21:0] f0_out, // function 0 peripheral outputs
  input wire [21:0] f0_oe, // function 0 peripheral output enables
  output reg [21:0] f0_in, // function 0 peripheral inputs
  input wire [21:0] f2_out, // function 2 peripheral outputs
  input wire [21:0] f2_oe, // function 2 peripheral output enables
  output reg [21:0] f2_in, // function 2 peripheral inputs
  input wire [7:0] lp_gpio_out, // lp gpio outputs
  input wire [7:0] lp_gpio_oe, // lp gpio enables
  output reg [7:0] lp_gpio_in, // lp gpio inputs
  input wire [7:0] lp_periph_out, // lp peripheral outputs
  input wire [7:0] lp_periph_oe, // lp peripheral enables
  output reg [7:0] lp_periph_in, // lp peripheral inputs
  output wire debug_src_usb, // debug port taken from usb
  output wire usb_owns_pads // usb controller holds its pads
);

  ////////////////////////////////////////////////////////////////////
  // registers

  reg [43:0] sel_q;
  reg [7:0] lp_sel_q;
  reg usb_own_q;
  reg dbg_usb_q;

  // a reserved code keeps the old choice so one function stays live
  function [1:0] pick;
    input [1:0] old_sel;
    input [1:0] new_sel;
    begin
      pick = (new_sel == `FUNC_BAD) ? old_sel : new_sel; // [R1]
    end
  endfunction

  // constant seen by an unselected peripheral input
  function idle_level;
    input [21:0] low_mask;
    input integer n;
    begin
      idle_level = ~low_mask[n]; // [R2] [R3]
    end
  endfunction

  // one bit of a per-pad table, kept one bit wide on purpose
  function has_bit;
    input [21:0] mask;
    input integer n;
    begin
      has_bit = mask[n];
    end
  endfunction

  // function 0 direction class: output-only drives, tri-capable follows its enable
  function f0_drive;
    input integer n;
    input oe;
    begin
      if (!has_bit(`F0_OUT_MASK, n)) begin
        f0_drive = 1'b0;
      end else if (has_bit(`F0_TRI_MASK, n)) begin
        f0_drive = oe;
      end else begin
        f0_drive = 1'b1;
      end
    end
  endfunction

  // function 1 is always general io; function 0 only on the plain io pads
  function gpio_on;
    input [1:0] sel;
    input integer n;
    begin
      case (sel)
        `FUNC_1: gpio_on = 1'b1;
        `FUNC_0: gpio_on = has_bit(`F0_GPIO_MASK, n);
        default: gpio_on = 1'b0;
      endcase
    end
  endfunction

  // a live input follows its pad, any other sees its fixed idle level
  function fn_input;
    input live;
    input [21:0] in_mask;
    input [21:0] low_mask;
    input level;
    input integer n;
    begin
      if (live & has_bit(in_mask, n)) begin
        fn_input = level;
      end else begin
        fn_input = idle_level(low_mask, n);
      end
    end
  endfunction

  integer k;

  always @(posedge ref_clk) begin
    if (reset) begin
      sel_q <= `SEL_RST; // [R5]
      lp_sel_q <= `LP_SEL_RST;
      usb_own_q <= `USB_OWN_RST;
      dbg_usb_q <= `DBG_USB_RST;
    end else if (wr) begin
      case (addr)
        `SEL_LO_ADDR: begin
          for (k = 0; k < 16; k = k + 1) begin
            sel_q[2*k +: 2] <= pick(sel_q[2*k +: 2], wdata[2*k +: 2]);
          end
        end
        `SEL_HI_ADDR: begin
          for (k = 16; k < `NUM_PINS; k = k + 1) begin
            sel_q[2*k +: 2] <= pick(sel_q[2*k +: 2], wdata[2*(k-16) +: 2]);
          end
        end
        `LP_SEL_ADDR: begin
          lp_sel_q <= wdata[7:0]; // [R10]
        end
        `CTRL_ADDR: begin
          usb_own_q <= wdata[`CTRL_USB_OWN_BIT];
          dbg_usb_q <= wdata[`CTRL_DBG_USB_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  assign usb_owns_pads = usb_own_q;
  assign debug_src_usb = dbg_usb_q; // [R13]

  ////////////////////////////////////////////////////////////////////
  // register reads

  always @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `SEL_LO_ADDR: rdata <= sel_q[31:0];
        `SEL_HI_ADDR: rdata <= {20'h0_0000, sel_q[43:32]};
        `LP_SEL_ADDR: rdata <= {24'h00_0000, lp_sel_q};
        `CTRL_ADDR: rdata <= {30'h0000_0000, dbg_usb_q, usb_own_q};
        `STATUS_ADDR: rdata <= {31'h0000_0000, deep_sleep};
        `PAD_LEVEL_ADDR: rdata <= {10'h000, pad_in};
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // low-power mux, only consulted in deep sleep

  wire [7:0] lp_pad_out;
  wire [7:0] lp_pad_oe;
  wire [7:0] lp_gpio_in_d;
  wire [7:0] lp_periph_in_d;

  lowpower_mux u_lp (
    .lp_sel(lp_sel_q),
    .lp_gpio_out(lp_gpio_out),
    .lp_gpio_oe(lp_gpio_oe),
    .periph_out(lp_periph_out),
    .periph_oe(lp_periph_oe),
    .pad_in(pad_in[7:0]),
    .pad_out(lp_pad_out),
    .pad_oe(lp_pad_oe),
    .lp_gpio_in(lp_gpio_in_d),
    .periph_in(lp_periph_in_d)
  );

  ////////////////////////////////////////////////////////////////////
  // main routing

  reg [21:0] pad_out_d;
  reg [21:0] pad_oe_d;
  reg [21:0] gpio_in_d;
  reg [21:0] f0_in_d;
  reg [21:0] f2_in_d;
  reg [1:0] s;
  reg blocked;
  reg f0_live;
  reg f2_live;
  reg gpio_live;
  integer i;

  always @* begin
    pad_out_d = 22'h00_0000;
    pad_oe_d = 22'h00_0000;
    gpio_in_d = 22'h00_0000;
    f0_in_d = 22'h00_0000;
    f2_in_d = 22'h00_0000;
    s = `FUNC_0;
    blocked = 1'b0;
    f0_live = 1'b0;
    f2_live = 1'b0;
    gpio_live = 1'b0;
    for (i = 0; i < `NUM_PINS; i = i + 1) begin
      s = sel_q[2*i +: 2];
      // usb pads stay with the usb controller until software frees them
      blocked = deep_sleep | (usb_own_q & has_bit(`USB_MASK, i)); // [R6] [R12]
      // general io on function 1, and on function 0 where it is one
      gpio_live = ~blocked & gpio_on(s, i); // [R11]
      // moving debug to usb releases the dedicated debug pads
      f0_live = ~blocked & (s == `FUNC_0) & ~has_bit(`F0_GPIO_MASK, i) &
        ~(dbg_usb_q & has_bit(`DBG_MASK, i)); // [R13]
      f2_live = ~blocked & (s == `FUNC_2) & has_bit(`F2_MASK, i);
      if (gpio_live) begin
        pad_out_d[i] = gpio_out[i]; // [R4]
        pad_oe_d[i] = gpio_oe[i];
      end else if (f0_live) begin
        pad_out_d[i] = f0_out[i];
        pad_oe_d[i] = f0_drive(i, f0_oe[i]); // [R4]
      end else if (f2_live) begin
        pad_out_d[i] = f2_out[i];
        pad_oe_d[i] = f2_oe[i]; // [R4]
      end
      gpio_in_d[i] = gpio_live & pad_in[i];
      f0_in_d[i] = fn_input(f0_live, `F0_IN_MASK, `F0_IN_LOW_MASK, pad_in[i], i); // [R2] [R3]
      f2_in_d[i] = fn_input(f2_live, `F2_IN_MASK, `F2_IN_LOW_MASK, pad_in[i], i); // [R2] [R3]
    end
    // low-power pads are handed over as a whole while asleep
    if (deep_sleep) begin
      pad_out_d[7:0] = lp_pad_out; // [R7]
      pad_oe_d[7:0] = lp_pad_oe; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // one flop stage for all routed signals

  // pad and peripheral sides load on the same edge, so a selection change
  // never shows a drive on one side without the matching input on the other
  always @(posedge ref_clk) begin
    if (reset) begin
      pad_out <= 22'h00_0000;
      pad_oe <= 22'h00_0000;
      gpio_in <= 22'h00_0000;
      f0_in <= 22'h00_0000;
      f2_in <= 22'h00_0000;
      lp_gpio_in <= 8'h00;
      lp_periph_in <= 8'hFF;
    end else begin
      pad_out <= pad_out_d; // [R14]
      pad_oe <= pad_oe_d; // [R14]
      gpio_in <= gpio_in_d; // [R14]
      f0_in <= f0_in_d; // [R14]
      f2_in <= f2_in_d; // [R14]
      // lp side sees its pads only while it owns them
      lp_gpio_in <= deep_sleep ? lp_gpio_in_d : 8'h00; // [R7]
      lp_periph_in <= deep_sleep ? lp_periph_in_d : 8'hFF; // [R7]
    end
  end

endmodule
`default_nettype wire

/* verif/io_function_mux_assertions.sv */
// port-level assertions for the io function mux
`timescale 1ns/10ps
`default_nettype none
`include "io_function_mux_defines.vh"
module io_function_mux_assertions (
  input wire ref_clk, // clock
  input wire reset, // sync reset
  input wire [7:0] addr, // address
  input wire rd, // read strobe
  input wire [31:0] rdata, // read data
  input wire deep_sleep, // sleep level
  input wire [21:0] pad_oe, // pad enables
  input wire [21:0] gpio_in, // gpio inputs
  input wire [21:0] f0_in, // fn0 inputs
  input wire [21:0] f2_in, // fn2 inputs
  input wire [7:0] lp_gpio_in, // lp gpio inputs
  input wire [7:0] lp_periph_in, // lp periph inputs
  input wire debug_src_usb, // debug from usb
  input wire usb_owns_pads // usb holds pads
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  sleep_release_a: assert property (
    deep_sleep [*2] |-> pad_oe[21:8] == 14'h0000) else $error("main pads driven in sleep");
  sleep_switch_a: assert property (
    $rose(deep_sleep) |=> pad_oe[21:8] == 14'h0000 && gpio_in == 22'h00_0000)
    else $error("drive and inputs not switched together");
  awake_lp_a: assert property (
    !deep_sleep |=> lp_gpio_in == 8'h00 && lp_periph_in == 8'hFF) else $error("lp mux live awake");
  // on pads with inputs of both functions, f0_in and f2_in never both read low
  forced_high_a: assert property (
    !$past(reset) |-> (~f0_in & ~f2_in & `F0_IN_MASK & `F2_IN_MASK) == 22'h00_0000)
    else $error("unselected input not forced high");
  usb_release_a: assert property (
    usb_owns_pads |=> pad_oe[11:10] == 2'b00) else $error("usb pads driven while owned");
  ctrl_read_a: assert property (
    rd && addr == `CTRL_ADDR |=> rdata[1:0] == {debug_src_usb, usb_owns_pads})
    else $error("control readback wrong");
  status_read_a: assert property (
    rd && addr == `STATUS_ADDR |=> rdata[0] == $past(deep_sleep)) else $error("status wrong");
  reset_default_a: assert property (
    $fell(reset) |-> usb_owns_pads && !debug_src_usb && rdata == 32'h0000_0000)
    else $error("reset defaults wrong");
endmodule
bind io_function_mux io_function_mux_assertions u_chk (.ref_clk(ref_clk), .reset(reset),
  .addr(addr), .rd(rd), .rdata(rdata), .deep_sleep(deep_sleep), .pad_oe(pad_oe),
  .gpio_in(gpio_in), .f0_in(f0_in), .f2_in(f2_in), .lp_gpio_in(lp_gpio_in),
  .lp_periph_in(lp_periph_in), .debug_src_usb(debug_src_usb), .usb_owns_pads(usb_owns_pads));
`default_nettype wire

/* verif/pad_world_model.sv */
// board side of the pads: external drivers meet the chip drive
`timescale 1ns/10ps
`default_nettype none
module pad_world_model (
  input wire [21:0] pad_out, // chip drive level
  input wire [21:0] pad_oe, // chip drive enable
  input wire [21:0] ext_level, // board level on released pads
  output wire [21:0] pad_in // resolved pad level
);
  // released pad shows the board, never a stale chip level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the io function mux
`timescale 1ns/10ps
`default_nettype none
`include "io_function_mux_defines.vh"
module tb_top;
  logic ref_clk, reset, wr, rd, deep_sleep;
  logic [7:0] addr, lp_gpio_out, lp_gpio_oe, lp_periph_out, lp_periph_oe;
  logic [31:0] wdata;
  logic [21:0] gpio_out, gpio_oe, f0_out, f0_oe, f2_out, f2_oe, ext_level;
  wire [31:0] rdata;
  wire [21:0] pad_in, pad_out, pad_oe, gpio_in, f0_in, f2_in;
  wire [7:0] lp_gpio_in, lp_periph_in;
  wire debug_src_usb, usb_owns_pads;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  io_function_mux u_dut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .deep_sleep(deep_sleep), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in(gpio_in), .f0_out(f0_out), .f0_oe(f0_oe), .f0_in(f0_in), .f2_out(f2_out),
    .f2_oe(f2_oe), .f2_in(f2_in), .lp_gpio_out(lp_gpio_out), .lp_gpio_oe(lp_gpio_oe),
    .lp_gpio_in(lp_gpio_in), .lp_periph_out(lp_periph_out), .lp_periph_oe(lp_periph_oe),
    .lp_periph_in(lp_periph_in), .debug_src_usb(debug_src_usb), .usb_owns_pads(usb_owns_pads));
  pad_world_model u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
    .pad_in(pad_in));
  ////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // routing lands one edge after its cause, and a pad level loops back
  // through the board, so inputs trail the new drive by one more edge
  task settle;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    settle;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, e);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    {reset, wr, rd, deep_sleep} = 4'b1000;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    {gpio_out, gpio_oe, f0_out, f0_oe, f2_out, f2_oe} = '0;
    {lp_gpio_out, lp_gpio_oe, lp_periph_out, lp_periph_oe} = '0;
    ext_level = 22'h2A_5A5A;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(`CTRL_ADDR, 32'h0000_0001);
    rd_chk(`SEL_LO_ADDR, 32'h0000_0000);
    rd_chk(`LP_SEL_ADDR, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    chk(f0_in & `F0_IN_MASK, 32'h002A_0050);
    // pad 4 through gpio, then function 2, then a refused code
    @(posedge ref_clk);
    gpio_oe <= 22'h00_0010;
    f2_oe <= 22'h00_0010;
    wr_reg(`SEL_LO_ADDR, 32'h0000_0100);
    chk({f0_in[4], gpio_in[4], pad_oe[4]}, 32'h5);
    wr_reg(`SEL_LO_ADDR, 32'h0000_0200);
    chk({f0_in[4], f2_in[4], gpio_in[4], pad_oe[4]}, 32'h9);
    wr_reg(`SEL_LO_ADDR, 32'h0000_0300);
    rd_chk(`SEL_LO_ADDR, 32'h0000_0200);
    // debug port moved to usb frees the debug output pad
    wr_reg(`SEL_LO_ADDR, 32'h0000_0000);
    @(posedge ref_clk);
    f0_oe <= 22'h00_0080;
    settle;
    chk(pad_oe[7], 32'h1);
    wr_reg(`CTRL_ADDR, 32'h0000_0003);
    chk({debug_src_usb, pad_oe[7]}, 32'h2);
    // software takes the usb pads back before gpio use
    @(posedge ref_clk);
    gpio_oe <= 22'h00_0C00;
    wr_reg(`SEL_LO_ADDR, 32'h0050_0000);
    chk(pad_oe[11:10], 32'h0);
    wr_reg(`CTRL_ADDR, 32'h0000_0002);
    chk({usb_owns_pads, pad_oe[11:10]}, 32'h3);
    // every pad as gpio input
    @(posedge ref_clk);
    gpio_oe <= 22'h00_0000;
    wr_reg(`SEL_HI_ADDR, 32'h0000_0555);
    wr_reg(`SEL_LO_ADDR, 32'h5555_5555);
    chk(gpio_in, ext_level);
    chk(f0_in & `F0_IN_MASK, `F0_IN_MASK);
    rd_chk(`SEL_HI_ADDR, 32'h0000_0555);
    rd_chk(`PAD_LEVEL_ADDR, 32'h002A_5A5A);
    // deep sleep: lp gpio first, then lp peripherals on pins 4..7
    @(posedge ref_clk);
    lp_gpio_oe <= 8'h0F;
    lp_gpio_out <= 8'h05;
    lp_periph_oe <= 8'hF0;
    lp_periph_out <= 8'h30;
    deep_sleep <= 1'b1;
    settle;
    chk(pad_oe, 32'h0000_000F);
    chk({lp_gpio_in, lp_periph_in}, 32'h55FF);
    rd_chk(`STATUS_ADDR, 32'h0000_0001);
    wr_reg(`LP_SEL_ADDR, 32'h0000_00F0);
    chk({pad_oe[7:0], pad_out[7:0]}, 32'hFF35);
    chk({lp_periph_in, lp_gpio_in[3:0]}, 32'h3F5);
    @(posedge ref_clk);
    deep_sleep <= 1'b0;
    settle;
    chk({lp_gpio_in, lp_periph_in}, 32'h00FF);
    report_and_stop;
  end
endmodule
`default_nettype wire
